// file: core/irp_pkg.sv
// Constants and state layout shared by the interrupt priority resolver
package irp_pkg;

   // ------------------------------------------------------------
   // Register byte offsets on APB
   // ------------------------------------------------------------
   localparam logic [7:0] IRP_OFS_MASK = 8'h00;
   localparam logic [7:0] IRP_OFS_PRI_CMD = 8'h04;
   localparam logic [7:0] IRP_OFS_OP3 = 8'h08;
   localparam logic [7:0] IRP_OFS_POLL = 8'h0C;
   localparam logic [7:0] IRP_OFS_INIT4 = 8'h10;
   localparam logic [7:0] IRP_OFS_ISR = 8'h14;
   localparam logic [7:0] IRP_OFS_STATUS = 8'h18;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   // priority_command_word: [7] rotate, [6] level_select, [5] end_of_service, [2:0] target_level_bits
   localparam int IRP_PCW_ROT = 7;
   localparam int IRP_PCW_SL = 6;
   localparam int IRP_PCW_EOS = 5;
   // third_operation_word: [6] special_mask_enable, [5] special_mask_select, [2] poll_request
   localparam int IRP_OP3_SPECIAL_MASK_ENABLE = 6;
   localparam int IRP_OP3_SMM = 5;
   localparam int IRP_OP3_POLL = 2;
   // fourth_init_word: [1] auto_end_of_service, [0] 16-bit host mode
   localparam int IRP_INIT4_AEOS = 1;
   localparam int IRP_INIT4_HOST16 = 0;
   // Poll result byte: [7] pending flag, [2:0] polled_level_code
   localparam int IRP_POLL_FLAG = 7;
   // Status word: [7:0] requests, [8] interrupt out, [11:9] acked level, [12] ack busy
   localparam int IRP_ST_INT = 8;
   localparam int IRP_ST_LVL = 9;
   localparam int IRP_ST_BUSY = 12;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] IRP_MASK_RST = 8'h00;
   localparam logic [2:0] IRP_LOWEST_RST = 3'h7;
   localparam logic [2:0] IRP_DEFAULT_LVL = 3'h7;
   localparam logic [1:0] IRP_ACKS_8BIT = 2'h3;
   localparam logic [1:0] IRP_ACKS_16BIT = 2'h2;

   // ------------------------------------------------------------
   // Module state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] req_s1;
      logic [7:0] req_s2;
      logic ack_s1;
      logic ack_s2;
      logic ack_d;
      logic [7:0] req;
      logic [7:0] mask;
      logic [7:0] in_service_bits;
      logic [2:0] lowest;
      logic special_mask_select;
      logic aeos;
      logic host16;
      logic rot_aeos;
      logic poll_armed;
      logic in_ack;
      logic [1:0] ack_cnt;
      logic ack_hit;
      logic [2:0] ack_level;
      logic int_out;
      logic [31:0] prdata;
      logic pslverr;
   } irp_state_t;

endpackage : irp_pkg

// file: core/irp_resolver.sv
// Eight-level interrupt priority resolver with in-service tracking, APB register access
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module irp_resolver import irp_pkg::*; #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Request pins, asynchronous to pclk
   input wire logic [7:0] req_in,
   // Acknowledge pin, active low pulses from the host
   input wire logic ack_pulse_n,
   // Towards the host
   output logic int_out,
   output logic [2:0] ack_level,
   output logic ack_busy
);

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   // Only the low eight address bits are decoded; wider buses alias.
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("irp_resolver: ADDR_W must be between 5 and 32");
   end

   // ------------------------------------------------------------
   // Priority helpers
   // ------------------------------------------------------------
   // Returns {found, level} of the highest set bit; the level just above
   // the lowest one ranks first.
   function automatic logic [3:0] irp_pick(input logic [7:0] bits, input logic [2:0] low);
      logic [3:0] res;
      logic [2:0] lvl;
      res = {1'b0, IRP_DEFAULT_LVL};
      lvl = low;
      for (int k = 8; k >= 1; k--) begin
         lvl = 3'(low + 3'(k));
         if (bits[lvl]) begin
            res = {1'b1, lvl};
         end
      end
      return res;
   endfunction : irp_pick

   // Rank 0 is the highest priority under the current rotation
   function automatic logic [2:0] irp_rank(input logic [2:0] lvl, input logic [2:0] low);
      return 3'(lvl - low - 3'h1);
   endfunction : irp_rank

   function automatic logic [7:0] irp_onehot(input logic [2:0] lvl);
      return 8'h01 << lvl;
   endfunction : irp_onehot

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   irp_state_t s;
   irp_state_t next_s;

   logic [7:0] cand;
   logic [7:0] eff_isr;
   logic [3:0] req_pick;
   logic [3:0] isr_pick;
   logic grant;
   logic ack_fall;
   logic ack_rise;
   logic [1:0] last_ack;
   logic setup;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] addr;
   logic mapped;
   logic [3:0] eos_pick;
   logic [7:0] pcw;
   logic [2:0] tgt;

   // How priority is reckoned
   // The register lowest names the level that currently ranks last; the
   // level one above it, modulo eight, ranks first. Reset leaves lowest at
   // seven, which gives the fixed order with level zero on top. Rotation
   // never reorders the levels, it only moves this one pointer, so every
   // comparison goes through irp_rank rather than the raw level numbers.
   //
   // A request reaches the host only when it is pending, unmasked and
   // strictly above the best level in service. Equal rank loses on
   // purpose: a level already being handled must not interrupt itself.
   //
   // In special mask mode the in-service bits stop inhibiting, so lower
   // levels may nest under a running handler. A level already in service
   // is still kept out of the candidates, otherwise a level-sensed input
   // held high would be granted again and again.

   // ------------------------------------------------------------
   // Resolver
   // ------------------------------------------------------------
   always_comb begin
      // Masked channels drop out one by one; in special mask mode the
      // in-service bits only keep their own levels out of the candidates.
      eff_isr = s.special_mask_select ? 8'h00 : s.in_service_bits;
      cand = s.req & ~s.mask & ~(s.special_mask_select ? s.in_service_bits : 8'h00);
      req_pick = irp_pick(cand, s.lowest);
      isr_pick = irp_pick(eff_isr, s.lowest);
      // Request must strictly outrank the highest level in service
      grant = req_pick[3] && (!isr_pick[3] ||
         irp_rank(req_pick[2:0], s.lowest) < irp_rank(isr_pick[2:0], s.lowest));
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      addr = 8'(paddr);
      setup = psel && !penable;
      wr_acc = psel && penable && pwrite;
      rd_acc = psel && penable && !pwrite;
      last_ack = s.host16 ? IRP_ACKS_16BIT : IRP_ACKS_8BIT;
      ack_fall = s.ack_d && !s.ack_s2;
      ack_rise = !s.ack_d && s.ack_s2;
      eos_pick = 4'h0;
      pcw = pwdata[7:0];
      tgt = pwdata[2:0];

      // Two-stage synchronisers
      next_s.req_s1 = req_in;
      next_s.req_s2 = s.req_s1;
      next_s.ack_s1 = ack_pulse_n;
      next_s.ack_s2 = s.ack_s1;
      next_s.ack_d = s.ack_s2;

      // Request state freezes while a poll or acknowledge is open so the
      // level reported cannot move under the host.
      if (!s.poll_armed && !s.in_ack) begin
         next_s.req = s.req_s2;
      end

      next_s.int_out = grant && !s.poll_armed;


      // Acknowledge sequence
      // The pin is sampled through two flip-flops and one more stage that
      // remembers the previous level, so a falling edge is seen three
      // clocks after the pin drops. The grant is taken at that edge and the
      // in-service bit is set at once, which drops the interrupt output on
      // the next clock. The pulses that follow are only counted; the rising
      // edge of the last one closes the sequence and, in auto mode, performs
      // the non-specific end-of-service. A request that has gone away by the
      // falling edge yields the default level and marks nothing in service,
      // so software can tell a glitch from a genuine level seven request.
      // Limitation: pulses shorter than one clock low or high may be lost.
      // Acknowledge sequence from the pin
      if (ack_fall && !s.in_ack) begin
         next_s.in_ack = 1'b1;
         next_s.ack_cnt = 2'h0;
         if (grant) begin
            next_s.in_service_bits = s.in_service_bits | irp_onehot(req_pick[2:0]);
            next_s.ack_level = req_pick[2:0];
            next_s.ack_hit = 1'b1;
         end else begin
            // Vanished request: default level, nothing goes in service
            next_s.ack_level = IRP_DEFAULT_LVL;
            next_s.ack_hit = 1'b0;
         end
      end
      if (ack_rise && s.in_ack) begin
         if (2'(s.ack_cnt + 2'h1) == last_ack) begin
            next_s.in_ack = 1'b0;
            next_s.ack_cnt = 2'h0;
            if (s.aeos && s.ack_hit) begin
               eos_pick = irp_pick(next_s.in_service_bits & ~(s.special_mask_select ? s.mask : 8'h00), s.lowest);
               if (eos_pick[3]) begin
                  next_s.in_service_bits = next_s.in_service_bits & ~irp_onehot(eos_pick[2:0]);
                  if (s.rot_aeos) begin
                     next_s.lowest = eos_pick[2:0];
                  end
               end
            end
         end else begin
            next_s.ack_cnt = 2'(s.ack_cnt + 2'h1);
         end
      end


      // Register map, one register per word, each a byte wide except status
      //   mask       read and write
      //   priority   write commands, read back the lowest level
      //   third word write mode bits, read special mask and poll armed
      //   poll       read only, valid once a poll is armed
      //   fourth     read and write, auto mode and host width
      //   in-service read only
      //   status     read only, latched requests and acknowledge state
      // Forming the read word in the setup cycle keeps prdata a flip-flop
      // output; the cost is that a read shows the state one clock before
      // the access edge, which is harmless because nothing here moves
      // faster than the synchronisers.
      // Read data and error are formed in the setup cycle and held
      // through the access cycle.
      mapped = 1'b1;
      if (setup) begin
         next_s.prdata = 32'h0000_0000;
         unique case (addr)
            IRP_OFS_MASK: next_s.prdata[7:0] = s.mask;
            IRP_OFS_PRI_CMD: next_s.prdata[2:0] = s.lowest;
            IRP_OFS_OP3: begin
               next_s.prdata[IRP_OP3_SMM] = s.special_mask_select;
               next_s.prdata[IRP_OP3_POLL] = s.poll_armed;
            end
            IRP_OFS_POLL: begin
               if (s.poll_armed && req_pick[3]) begin
                  next_s.prdata[IRP_POLL_FLAG] = 1'b1;
                  next_s.prdata[2:0] = req_pick[2:0];
               end
            end
            IRP_OFS_INIT4: begin
               next_s.prdata[IRP_INIT4_AEOS] = s.aeos;
               next_s.prdata[IRP_INIT4_HOST16] = s.host16;
            end
            IRP_OFS_ISR: next_s.prdata[7:0] = s.in_service_bits;
            IRP_OFS_STATUS: begin
               next_s.prdata[7:0] = s.req;
               next_s.prdata[IRP_ST_INT] = s.int_out;
               next_s.prdata[IRP_ST_LVL +: 3] = s.ack_level;
               next_s.prdata[IRP_ST_BUSY] = s.in_ack;
            end
            default: mapped = 1'b0;
         endcase
         next_s.pslverr = !mapped || (pwrite && (addr == IRP_OFS_POLL || addr == IRP_OFS_ISR ||
            addr == IRP_OFS_STATUS));
      end

      // Writes take effect at the access edge
      if (wr_acc && !s.pslverr) begin
         unique case (addr)
            IRP_OFS_MASK: next_s.mask = pwdata[7:0];
            IRP_OFS_PRI_CMD: begin
               // Non-specific uses the rotation before any change
               eos_pick = irp_pick(next_s.in_service_bits & ~(s.special_mask_select ? s.mask : 8'h00), s.lowest);
               // Command codes, bits rotate, level select, end-of-service:
               //   001 clear the best level in service
               //   011 clear the named level
               //   101 clear the best level and make it lowest
               //   100 rotate on auto end-of-service from now on
               //   000 stop rotating on auto end-of-service
               //   111 clear the named level and make it lowest
               //   110 make the named level lowest, nothing cleared
               //   010 no operation
               unique case ({pcw[IRP_PCW_ROT], pcw[IRP_PCW_SL], pcw[IRP_PCW_EOS]})
                  3'h1: begin
                     if (eos_pick[3]) begin
                        next_s.in_service_bits = next_s.in_service_bits & ~irp_onehot(eos_pick[2:0]);
                     end
                  end
                  3'h3: next_s.in_service_bits = next_s.in_service_bits & ~irp_onehot(tgt);
                  3'h5: begin
                     if (eos_pick[3]) begin
                        next_s.in_service_bits = next_s.in_service_bits & ~irp_onehot(eos_pick[2:0]);
                        next_s.lowest = eos_pick[2:0];
                     end
                  end
                  3'h4: next_s.rot_aeos = 1'b1;
                  3'h0: next_s.rot_aeos = 1'b0;
                  3'h7: begin
                     next_s.in_service_bits = next_s.in_service_bits & ~irp_onehot(tgt);
                     next_s.lowest = tgt;
                  end
                  3'h6: next_s.lowest = tgt;
                  3'h2: begin
                  end
               endcase
            end
            IRP_OFS_OP3: begin
               if (pwdata[IRP_OP3_SPECIAL_MASK_ENABLE]) begin
                  next_s.special_mask_select = pwdata[IRP_OP3_SMM];
               end
               if (pwdata[IRP_OP3_POLL]) begin
                  next_s.poll_armed = 1'b1;
               end
            end
            IRP_OFS_INIT4: begin
               next_s.aeos = pwdata[IRP_INIT4_AEOS];
               next_s.host16 = pwdata[IRP_INIT4_HOST16];
            end
            default: begin
            end
         endcase
      end


      // The poll read closes the poll whether or not anything was pending,
      // so a second read without a fresh poll command returns zero.
      // Requests stay frozen until this edge, which keeps the byte formed
      // in the setup cycle and the bit set here in agreement.
      // A poll read is the acknowledge; with nothing pending it only closes the poll
      if (rd_acc && addr == IRP_OFS_POLL && s.poll_armed) begin
         next_s.poll_armed = 1'b0;
         if (req_pick[3]) begin
            next_s.in_service_bits = next_s.in_service_bits | irp_onehot(req_pick[2:0]);
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // The acknowledge synchroniser resets to the idle high level so that
   // release of reset is not mistaken for a falling edge on the pin.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.req_s1 <= 8'h00;
         s.ack_s1 <= 1'b1;
         s.ack_s2 <= 1'b1;
         s.ack_d <= 1'b1;
         s.mask <= IRP_MASK_RST;
         s.lowest <= IRP_LOWEST_RST;
         s.ack_level <= IRP_DEFAULT_LVL;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // No wait states: every transfer is one setup and one access cycle.
   assign pready = 1'b1;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr && psel && penable;
   assign int_out = s.int_out;
   assign ack_level = s.ack_level;
   assign ack_busy = s.in_ack;

endmodule : irp_resolver

`default_nettype wire

// file: tb/irp_resolver_monitor.sv
// Port-level checks of the interrupt priority resolver
`timescale 1ns/1ps
`default_nettype none
module irp_resolver_monitor import irp_pkg::*; #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic [7:0] req_in,
   input wire logic ack_pulse_n,
   input wire logic int_out,
   input wire logic [2:0] ack_level,
   input wire logic ack_busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr = psel && penable && pwrite;
   wire logic rd = psel && penable && !pwrite;
   a_ready_high: assert property (pready) else $error("pready low");
   a_busy_rise: assert property ($rose(ack_busy) |-> !$past(ack_pulse_n, 1) && !$past(ack_pulse_n, 2))
      else $error("ack opened without low pin");
   a_busy_fall: assert property ($fell(ack_busy) |-> $past(ack_pulse_n, 1) && $past(ack_pulse_n, 2))
      else $error("ack closed without rising pin");
   a_busy_hold: assert property ($rose(ack_busy) |-> ack_busy[*8]) else $error("ack closed early");
   a_poll_quiet: assert property (wr && paddr[7:0] == IRP_OFS_OP3 && pwdata[IRP_OP3_POLL] |-> ##2 !int_out)
      else $error("interrupt while poll armed");
   a_refused_wr: assert property (wr && paddr[7:0] == IRP_OFS_ISR |-> pslverr) else $error("write not refused");
   a_unmapped_rd: assert property (rd && paddr[7:0] == 8'h1C |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read");
   a_status_mirror: assert property (rd && paddr[7:0] == IRP_OFS_STATUS |-> prdata[IRP_ST_INT] == $past(int_out)
      && prdata[11:9] == $past(ack_level) && prdata[IRP_ST_BUSY] == $past(ack_busy))
      else $error("status mismatch");
   a_poll_byte: assert property (rd && paddr[7:0] == IRP_OFS_POLL |-> prdata[31:8] == 0 && prdata[6:3] == 0)
      else $error("poll byte format");
endmodule : irp_resolver_monitor
bind irp_resolver irp_resolver_monitor #(.ADDR_W(ADDR_W)) i_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_in(req_in),
   .ack_pulse_n(ack_pulse_n), .int_out(int_out), .ack_level(ack_level), .ack_busy(ack_busy)
);
`default_nettype wire

// file: tb/irp_host_model.sv
// Host side that issues acknowledge pulse trains
`timescale 1ns/1ps
`default_nettype none
module irp_host_model (
   // Control from the bench
   input wire logic pclk,
   input wire logic start,
   input wire logic host16,
   input wire logic slow,
   // Towards the resolver, and done back to the bench
   output logic ack_pulse_n,
   output logic done
);
   initial begin
      ack_pulse_n = 1'b1;
      done = 1'b0;
   end
   // Widths of 3 or 6 cycles both meet the synchroniser minimum
   always @(posedge pclk) begin
      done <= 1'b0;
      if (start) begin
         for (int i = 0; i < (host16 ? 2 : 3); i++) begin
            ack_pulse_n <= 1'b0;
            repeat (slow ? 6 : 3) @(posedge pclk);
            ack_pulse_n <= 1'b1;
            repeat (slow ? 6 : 3) @(posedge pclk);
         end
         done <= 1'b1;
      end
   end
endmodule : irp_host_model
`default_nettype wire

// file: tb/irp_resolver_bench.sv
// Self-checking bench for the interrupt priority resolver
`timescale 1ns/1ps
`default_nettype none
module irp_resolver_bench import irp_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, req_in = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic pready, pslverr, ack_pulse_n, int_out, ack_busy, done;
   logic start = 1'b0, host16 = 1'b0, slow = 1'b0;
   logic [2:0] ack_level;
   logic [7:0] ofs[5] = '{IRP_OFS_MASK, IRP_OFS_ISR, IRP_OFS_PRI_CMD, IRP_OFS_INIT4, 8'h1C};
   int rexp[5] = '{0, 0, 7, 0, 0};
   int cmds[8] = '{1, 3, 5, 7, 6, 4, 0, 2};
   int failures = 0, total_checks = 0, cyc = 0;
   int mask_m = 0, isr_m = 0, low_m = 7, rot_m = 0, smm_m = 0, rq = 0, lv, i4, c;
   always #10 pclk = ~pclk;
   irp_resolver #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_in(req_in), .ack_pulse_n(ack_pulse_n), .int_out(int_out), .ack_level(ack_level), .ack_busy(ack_busy));
   irp_host_model i_host (.pclk(pclk), .start(start), .host16(host16), .slow(slow),
      .ack_pulse_n(ack_pulse_n), .done(done));
   // ------------------------------------------------------------
   // Reference model and bus tasks
   // ------------------------------------------------------------
   function automatic int rank(int l);
      return (l - low_m + 7) % 8;
   endfunction : rank
   function automatic int top(int bits);
      int b;
      b = -1;
      for (int i = 0; i < 8; i++) if (bits[i] && (b < 0 || rank(i) < rank(b))) b = i;
      return b;
   endfunction : top
   function automatic logic int_exp();
      int p;
      p = rq & ~mask_m & 255;
      if (smm_m != 0) return (p & ~isr_m) != 0;
      return top(p) >= 0 && (isr_m == 0 || rank(top(p)) < rank(top(isr_m)));
   endfunction : int_exp
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [7:0] a, input int d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_isr();
      apb(1'b0, IRP_OFS_ISR, 0, r);
      cmp(r, isr_m);
   endtask : rd_isr
   task automatic setmask(input int m);
      apb(1'b1, IRP_OFS_MASK, m, r);
      mask_m = m;
   endtask : setmask
   task automatic chk_int();
      repeat (6) @(posedge pclk);
      cmp(int_out, int_exp());
   endtask : chk_int
   task automatic ack(input int mode, input int sl);
      int n;
      lv = top(rq & ~mask_m & 255);
      host16 <= mode[0];
      slow <= sl[0];
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      repeat (4) @(posedge pclk);
      isr_m[lv] = 1'b1;
      if (mode[1]) begin
         isr_m[lv] = 1'b0;
         if (rot_m != 0) low_m = lv;
      end
      cmp(ack_level, lv);
      rd_isr();
   endtask : ack
   task automatic cmd(input int cc, input int l);
      int t;
      apb(1'b1, IRP_OFS_PRI_CMD, (cc << 5) | l, r);
      t = smm_m != 0 ? top(isr_m & ~mask_m & 255) : top(isr_m);
      case (cc)
         1: if (t >= 0) isr_m[t] = 1'b0;
         3: isr_m[l] = 1'b0;
         5: if (t >= 0) begin
            isr_m[t] = 1'b0;
            low_m = t;
         end
         7: begin
            isr_m[l] = 1'b0;
            low_m = l;
         end
         6: low_m = l;
         4: rot_m = 1;
         0: rot_m = 0;
         default: ;
      endcase
   endtask : cmd
   task automatic clear_all();
      apb(1'b1, IRP_OFS_INIT4, 0, r);
      for (int l = 0; l < 8; l++) cmd(3, l);
   endtask : clear_all
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      void'($urandom(11394));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 0, r);
         cmp(r, rexp[i]);
      end
      apb(1'b0, IRP_OFS_STATUS, 0, r);
      apb(1'b1, IRP_OFS_ISR, 255, r);
      rd_isr();
      $display("test reset done");
      for (int k = 0; k < 24; k++) begin
         i4 = $urandom_range(0, 3);
         apb(1'b1, IRP_OFS_INIT4, i4, r);
         apb(1'b0, IRP_OFS_INIT4, 0, r);
         cmp(r, i4);
         setmask($urandom & $urandom & 255);
         rq = $urandom_range(1, 255);
         req_in <= rq[7:0];
         chk_int();
         if (int_exp()) ack(i4, k % 2);
         c = cmds[$urandom_range(0, 7)];
         if (c == 5 && isr_m == 0) c = 2;
         cmd(c, $urandom_range(0, 7));
         rd_isr();
         apb(1'b0, IRP_OFS_PRI_CMD, 0, r);
         cmp(r, low_m);
      end
      $display("test rounds done");
      clear_all();
      for (int j = 0; j < 2; j++) begin
         setmask(j != 0 ? 0 : 255);
         rq = $urandom_range(1, 255);
         req_in <= rq[7:0];
         repeat (6) @(posedge pclk);
         apb(1'b1, IRP_OFS_OP3, 32'h0000_0004, r);
         apb(1'b0, IRP_OFS_OP3, 0, r);
         cmp(r, 32'h0000_0004);
         req_in <= ~rq[7:0];
         repeat (6) @(posedge pclk);
         apb(1'b0, IRP_OFS_POLL, 0, r);
         lv = top(rq & ~mask_m & 255);
         cmp(r, lv < 0 ? 0 : 32'h0000_0080 | lv);
         if (lv >= 0) isr_m[lv] = 1'b1;
         rd_isr();
      end
      $display("test poll done");
      clear_all();
      setmask(0);
      rq = 1;
      req_in <= 8'h01;
      chk_int();
      ack(0, 0);
      rq = 32'h21;
      req_in <= 8'h21;
      chk_int();
      apb(1'b1, IRP_OFS_OP3, 32'h0000_0060, r);
      smm_m = 1;
      chk_int();
      setmask(32'h21);
      chk_int();
      cmd(1, 0);
      rd_isr();
      cmd(3, 0);
      rd_isr();
      apb(1'b1, IRP_OFS_OP3, 32'h0000_0040, r);
      smm_m = 0;
      setmask(0);
      chk_int();
      $display("test special mask done");
      end_sim();
   end
endmodule : irp_resolver_bench
`default_nettype wire
